/* File: rtl/cfs_cfg_mem.v */
// Stored configuration memory, four words, registered read
`timescale 1ns/1ps
`default_nettype none

module cfs_cfg_mem #(
   parameter W = 16,
   parameter [W-1:0] CFG0 = 16'h0000,
   parameter [W-1:0] CFG1 = 16'h0000,
   parameter [W-1:0] CFG2 = 16'h0000,
   parameter [W-1:0] CFG3 = 16'h0000
) (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Read port
   input wire [1:0] rd_addr,
   output reg [W-1:0] rd_data
);

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_data <= {W{1'b0}};
      end else begin
         case (rd_addr)
            2'h0: rd_data <= CFG0;
            2'h1: rd_data <= CFG1;
            2'h2: rd_data <= CFG2;
            default: rd_data <= CFG3;
         endcase
      end
   end

endmodule // cfs_cfg_mem

`default_nettype wire

/* File: rtl/cfs_defs.vh */
// Constants for the configuration select and input mux block
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CFS_REG0_ADDR 8'h00
`define CFS_REG13_ADDR 8'h13
`define CFS_REG0_RST 8'h00
`define CFS_REG13_RST 8'h00
`define CFS_DEFAULTS_BIT 7
`define CFS_PRIMARY_SOURCE_BIT_BIT 1
`define CFS_SM_HI_BIT 7

// ----------------------------------------
// Serial port
// ----------------------------------------
`define CFS_I2C_ADDR 7'h6a

// ----------------------------------------
// Timing
// ----------------------------------------
`define CFS_CLK_KHZ 25000
`define CFS_POWERUP_MS 10
`define CFS_SETTLE_MS 1
`define CFS_POWERUP_CYC (`CFS_POWERUP_MS * `CFS_CLK_KHZ)
`define CFS_SETTLE_CYC (`CFS_SETTLE_MS * `CFS_CLK_KHZ)
`define CFS_STRAP_WAIT 2'h3

`endif

/* File: rtl/cfs_top.v */
// Power-up strap, configuration select and reference input select
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defs.vh"

module cfs_top #(
   parameter POWERUP_CYCLES = `CFS_POWERUP_CYC,
   parameter SETTLE_CYCLES = `CFS_SETTLE_CYC,
   parameter [6:0] SLAVE_ADDR = `CFS_I2C_ADDR,
   parameter [15:0] CFG0 = 16'h0000,
   parameter [15:0] CFG1 = 16'h0001,
   parameter [15:0] CFG2 = 16'h0002,
   parameter [15:0] CFG3 = 16'h0003
) (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Strap pin, later reference output
   input wire strap_select_pin_in,
   output reg strap_select_pin_out,
   output reg strap_select_pin_oe_n,
   input wire ref_out_level,
   // Shared pins: config_select_high or data, config_select_low or clock
   input wire cfg_sel_high_sda_in,
   output wire cfg_sel_high_sda_out,
   output wire cfg_sel_high_sda_oe_n,
   input wire cfg_sel_low_scl_in,
   // Reference input select
   input wire input_source_pin,
   output reg diff_input_selected,
   // Configuration state
   output reg hw_select_mode,
   output reg [1:0] config_index,
   output reg config_load,
   output reg config_busy,
   output reg [7:0] stored_defaults_reg,
   output reg [7:0] input_source_polarity_config
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_STRAP = 5'h01;
   localparam ST_READ = 5'h02;
   localparam ST_APPLY = 5'h04;
   localparam ST_SETTLE = 5'h08;
   localparam ST_RUN = 5'h10;

   localparam PH_IDLE = 2'h0;
   localparam PH_ADDR = 2'h1;
   localparam PH_PTR = 2'h2;
   localparam PH_DATA = 2'h3;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   reg [3:0] sync1_q;
   reg [3:0] sync2_q;
   wire [3:0] pins_raw;
   assign pins_raw = {input_source_pin, cfg_sel_low_scl_in,
                      cfg_sel_high_sda_in, strap_select_pin_in};

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   wire strap_s = sync2_q[0];
   wire sda_s = sync2_q[1];
   wire scl_s = sync2_q[2];
   wire input_source_pin_s = sync2_q[3];
   wire [1:0] pin_index = {sda_s, scl_s};

   // ----------------------------------------
   // Power-up sequencing and config loads
   // ----------------------------------------
   reg [4:0] state_q;
   reg [1:0] strap_cnt_q;
   reg [23:0] pu_cnt_q;
   reg [23:0] settle_cnt_q;
   reg [1:0] mem_addr_q;
   reg boot_q;
   wire [15:0] mem_word;
   wire pu_done = (pu_cnt_q == POWERUP_CYCLES[23:0]);

   cfs_cfg_mem #(
      .W(16),
      .CFG0(CFG0),
      .CFG1(CFG1),
      .CFG2(CFG2),
      .CFG3(CFG3)
   ) u_mem (
      .clock(clock),
      .nrst(nrst),
      .rd_addr(mem_addr_q),
      .rd_data(mem_word)
   );

   // Serial register write strobe from the slave below
   reg wr_en;
   reg [7:0] wr_addr;
   reg [7:0] wr_data;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pu_cnt_q <= 24'h0;
      end else if (!pu_done) begin
         pu_cnt_q <= pu_cnt_q + 24'h1;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_STRAP;
         strap_cnt_q <= 2'h0;
         settle_cnt_q <= 24'h0;
         mem_addr_q <= 2'h0;
         boot_q <= 1'b1;
         hw_select_mode <= 1'b0;
         config_index <= 2'h0;
         config_load <= 1'b0;
         config_busy <= 1'b1;
         strap_select_pin_oe_n <= 1'b1;
         strap_select_pin_out <= 1'b0;
         stored_defaults_reg <= `CFS_REG0_RST;
         input_source_polarity_config <= `CFS_REG13_RST;
      end else begin
         config_load <= 1'b0;
         if (state_q != ST_STRAP) begin
            strap_select_pin_out <= ref_out_level;
         end
         if (wr_en && wr_addr == `CFS_REG13_ADDR) begin
            input_source_polarity_config <= wr_data;
         end
         if (wr_en && wr_addr == `CFS_REG0_ADDR) begin
            stored_defaults_reg <= wr_data;
         end
         case (state_q)
            ST_STRAP: begin
               // Wait for the synchroniser to hold the real pin level
               strap_cnt_q <= strap_cnt_q + 2'h1;
               if (strap_cnt_q == `CFS_STRAP_WAIT) begin
                  hw_select_mode <= strap_s;
                  strap_select_pin_oe_n <= 1'b0;
                  // index from pins; fixed zero otherwise
                  mem_addr_q <= strap_s ? pin_index : 2'h0;
                  state_q <= ST_READ;
               end
            end
            ST_READ: begin
               state_q <= ST_APPLY;
            end
            ST_APPLY: begin
               config_index <= mem_addr_q;
               config_load <= 1'b1;
               stored_defaults_reg <= mem_word[15:8];
               input_source_polarity_config <= mem_word[7:0];
               // Serial mode with defaults flag keeps reset values, with the defaults flag set in stored_defaults_reg
               if (boot_q && !hw_select_mode &&
                   mem_word[8 + `CFS_DEFAULTS_BIT]) begin
                  stored_defaults_reg <= `CFS_REG0_RST |
                     (8'h01 << `CFS_DEFAULTS_BIT);
                  input_source_polarity_config <= `CFS_REG13_RST;
               end
               boot_q <= 1'b0;
               settle_cnt_q <= 24'h0;
               state_q <= ST_SETTLE;
            end
            ST_SETTLE: begin
               // hold off further loads for the settle time
               settle_cnt_q <= settle_cnt_q + 24'h1;
               if (settle_cnt_q == SETTLE_CYCLES[23:0] - 24'h1) begin
                  config_busy <= 1'b0;
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               // only after power-up time, flag clear, pin mode
               // compare with last loaded index, one load each
               if (hw_select_mode && pu_done &&
                   !stored_defaults_reg[`CFS_DEFAULTS_BIT] &&
                   pin_index != config_index) begin
                  mem_addr_q <= pin_index;
                  config_busy <= 1'b1;
                  state_q <= ST_READ;
               end
            end
            default: begin
               state_q <= ST_STRAP;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Reference input select
   // ----------------------------------------
   // pin control only in manual mode; registered so it cannot glitch
   // pin XOR polarity picks differential input
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         diff_input_selected <= 1'b0;
      end else if (state_q != ST_STRAP &&
                   !input_source_polarity_config[`CFS_SM_HI_BIT]) begin
         diff_input_selected <= input_source_pin_s ^
            input_source_polarity_config[`CFS_PRIMARY_SOURCE_BIT_BIT];
      end
   end

   // ----------------------------------------
   // Serial slave port
   // ----------------------------------------
   reg sda_d1_q;
   reg scl_d1_q;
   reg [1:0] phase_q;
   reg [3:0] bitcnt_q;
   reg [7:0] shift_q;
   reg [7:0] rdbuf_q;
   reg [7:0] ptr_q;
   reg rw_q;
   reg ack_slot_q;
   reg drive_low_q;

   // port lives only in serial strap mode
   wire i2c_on = !hw_select_mode && state_q != ST_STRAP;
   wire scl_rise = i2c_on && scl_s && !scl_d1_q;
   wire scl_fall = i2c_on && !scl_s && scl_d1_q;
   wire start_c = i2c_on && scl_s && scl_d1_q && !sda_s && sda_d1_q;
   wire stop_c = i2c_on && scl_s && scl_d1_q && sda_s && !sda_d1_q;
   wire reading = (phase_q == PH_DATA) && rw_q;

   // Register read decode
   function [7:0] reg_read;
      input [7:0] addr;
      begin
         if (addr == `CFS_REG0_ADDR) begin
            reg_read = stored_defaults_reg;
         end else if (addr == `CFS_REG13_ADDR) begin
            reg_read = input_source_polarity_config;
         end else begin
            reg_read = 8'h00;
         end
      end
   endfunction

   // Next read byte, decoded once for both buffer and first bit
   wire [7:0] rd_next = reg_read(ptr_q);

   assign cfg_sel_high_sda_out = 1'b0;
   assign cfg_sel_high_sda_oe_n = !(drive_low_q && i2c_on);

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sda_d1_q <= 1'b1;
         scl_d1_q <= 1'b1;
         phase_q <= PH_IDLE;
         bitcnt_q <= 4'h0;
         shift_q <= 8'h00;
         rdbuf_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         ack_slot_q <= 1'b0;
         drive_low_q <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         sda_d1_q <= sda_s;
         scl_d1_q <= scl_s;
         wr_en <= 1'b0;
         if (start_c) begin
            phase_q <= PH_ADDR;
            bitcnt_q <= 4'h0;
            rw_q <= 1'b0;
            ack_slot_q <= 1'b0;
            drive_low_q <= 1'b0;
         end else if (stop_c || !i2c_on) begin
            phase_q <= PH_IDLE;
            drive_low_q <= 1'b0;
         end else if (phase_q != PH_IDLE && scl_rise) begin
            if (bitcnt_q == 4'h8) begin
               bitcnt_q <= 4'h0;
               // Master refusal of a read byte ends the transfer
               if (reading && sda_s) begin
                  phase_q <= PH_IDLE;
               end
            end else begin
               shift_q <= {shift_q[6:0], sda_s};
               bitcnt_q <= bitcnt_q + 4'h1;
            end
         end else if (phase_q != PH_IDLE && scl_fall) begin
            ack_slot_q <= 1'b0;
            drive_low_q <= 1'b0;
            if (bitcnt_q == 4'h8) begin
               ack_slot_q <= !reading;
               case (phase_q)
                  PH_ADDR: begin
                     if (shift_q[7:1] == SLAVE_ADDR) begin
                        drive_low_q <= 1'b1;
                        rw_q <= shift_q[0];
                        phase_q <= shift_q[0] ? PH_DATA : PH_PTR;
                     end else begin
                        phase_q <= PH_IDLE;
                     end
                  end
                  PH_PTR: begin
                     ptr_q <= shift_q;
                     drive_low_q <= 1'b1;
                     phase_q <= PH_DATA;
                  end
                  default: begin
                     if (!rw_q) begin
                        wr_en <= 1'b1;
                        wr_addr <= ptr_q;
                        wr_data <= shift_q;
                        ptr_q <= ptr_q + 8'h01;
                        drive_low_q <= 1'b1;
                     end
                  end
               endcase
            end else if (bitcnt_q == 4'h0 && reading) begin
               // Ack done or master acked: next read byte out
               rdbuf_q <= rd_next;
               drive_low_q <= !rd_next[7];
               ptr_q <= ptr_q + 8'h01;
            end else if (reading && !ack_slot_q) begin
               drive_low_q <= !rdbuf_q[3'h7 - bitcnt_q[2:0]];
            end
         end
      end
   end

endmodule // cfs_top

`default_nettype wire

/* File: verification/cfs_host_model.sv */
// Host model: select pin driver and serial bus master
`timescale 1ns/1ps
`default_nettype none

module cfs_host_model (
   // Clock
   input wire logic clock,
   // Shared pins
   input wire logic dev_sda_oe_n,
   output wire logic pin_high,
   output wire logic pin_low
);
   logic sda_q = 1'b1;
   logic scl_q = 1'b1;
   // Open drain with pull-up
   assign pin_high = sda_q & dev_sda_oe_n;
   assign pin_low = scl_q;
   task automatic hold(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic set_both(input logic [1:0] p);
      sda_q <= p[1];
      scl_q <= p[0];
   endtask
   task automatic flip_one(input logic b);
      @(posedge clock);
      if (b)
         sda_q <= ~sda_q;
      else
         scl_q <= ~scl_q;
   endtask
   task automatic wr_byte(input logic [7:0] v, output logic ok);
      for (int i = 7; i >= 0; i--) begin
         scl_q <= 1'b0;
         hold(4);
         sda_q <= v[i];
         hold(4);
         scl_q <= 1'b1;
         hold(8);
      end
      scl_q <= 1'b0;
      hold(4);
      sda_q <= 1'b1;
      hold(4);
      scl_q <= 1'b1;
      hold(4);
      ok = !pin_high;
      hold(4);
   endtask
   // Device drives each bit a few cycles after the fall; sample late high
   task automatic rd_byte(input logic nack, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         scl_q <= 1'b0;
         sda_q <= 1'b1;
         hold(8);
         scl_q <= 1'b1;
         hold(4);
         v[i] = pin_high;
         hold(4);
      end
      scl_q <= 1'b0;
      hold(4);
      sda_q <= nack;
      hold(4);
      scl_q <= 1'b1;
      hold(8);
   endtask
   task automatic start_cond;
      @(posedge clock);
      sda_q <= 1'b0;
      hold(8);
   endtask
   task automatic stop_cond;
      scl_q <= 1'b0;
      hold(4);
      sda_q <= 1'b0;
      hold(4);
      scl_q <= 1'b1;
      hold(4);
      sda_q <= 1'b1;
      hold(8);
   endtask
   task automatic write_reg(input logic [7:0] dev, input logic [7:0] a,
         input logic [7:0] v, output logic acked);
      logic k1, k2, k3;
      start_cond;
      wr_byte(dev, k1);
      wr_byte(a, k2);
      wr_byte(v, k3);
      stop_cond;
      acked = k1 & k2 & k3;
   endtask
   // Pointer write, stop, then one byte read ended by a refusal
   task automatic read_reg(input logic [7:0] dev, input logic [7:0] a,
         output logic [7:0] v, output logic acked);
      logic k1, k2, k3;
      start_cond;
      wr_byte(dev, k1);
      wr_byte(a, k2);
      stop_cond;
      start_cond;
      wr_byte({dev[7:1], 1'b1}, k3);
      rd_byte(1'b1, v);
      stop_cond;
      acked = k1 & k2 & k3;
   endtask
endmodule // cfs_host_model

`default_nettype wire

/* File: verification/cfs_sva.sv */
// Assertion checker for the configuration select block
`timescale 1ns/1ps
`default_nettype none

module cfs_sva (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Pins
   input wire strap_select_pin_out,
   input wire strap_select_pin_oe_n,
   input wire ref_out_level,
   input wire cfg_sel_high_sda_in,
   input wire cfg_sel_high_sda_oe_n,
   input wire cfg_sel_low_scl_in,
   input wire input_source_pin,
   // State
   input wire diff_input_selected,
   input wire hw_select_mode,
   input wire [1:0] config_index,
   input wire config_load,
   input wire [7:0] stored_defaults_reg,
   input wire [7:0] input_source_polarity_config
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_ref;
      $past(!strap_select_pin_oe_n) |->
         strap_select_pin_out == $past(ref_out_level);
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference output not following its level");
   property p_mode_hold;
      $past(!strap_select_pin_oe_n) |-> $stable(hw_select_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("latched strap level changed");
   property p_no_ack;
      hw_select_mode |-> cfg_sel_high_sda_oe_n;
   endproperty
   a_no_ack: assert property (p_no_ack)
      else $error("data line pulled in pin select mode");
   property p_load_idx;
      config_load && hw_select_mode |->
         config_index == {cfg_sel_high_sda_in, cfg_sel_low_scl_in};
   endproperty
   a_load_idx: assert property (p_load_idx)
      else $error("loaded index differs from select pins");
   property p_flag;
      hw_select_mode && $past(stored_defaults_reg[7]) |-> !config_load;
   endproperty
   a_flag: assert property (p_flag)
      else $error("load while defaults flag set");
   property p_diff;
      (!strap_select_pin_oe_n && !input_source_polarity_config[7] &&
         $stable(input_source_pin) &&
         $stable(input_source_polarity_config)) [*5] |->
         diff_input_selected ==
         (input_source_pin ^ input_source_polarity_config[1]);
   endproperty
   a_diff: assert property (p_diff)
      else $error("input source selection wrong");
   property p_frozen;
      $past(input_source_polarity_config[7]) &&
         input_source_polarity_config[7] |-> $stable(diff_input_selected);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("source changed outside manual mode");
   property p_one;
      config_load |=> !config_load [*8];
   endproperty
   a_one: assert property (p_one)
      else $error("second load pulse too soon");

   c_load: cover property (config_load && hw_select_mode);
   c_ack: cover property (!cfg_sel_high_sda_oe_n);
   c_freeze: cover property (input_source_polarity_config[7]);
endmodule // cfs_sva

bind cfs_top cfs_sva u_sva (.clock, .nrst, .strap_select_pin_out,
   .strap_select_pin_oe_n, .ref_out_level, .cfg_sel_high_sda_in,
   .cfg_sel_high_sda_oe_n, .cfg_sel_low_scl_in, .input_source_pin,
   .diff_input_selected, .hw_select_mode, .config_index, .config_load,
   .stored_defaults_reg, .input_source_polarity_config);

`default_nettype wire

/* File: verification/cfs_tb_top.sv */
// Self-checking testbench for the configuration select block
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defs.vh"

module cfs_tb_top;
   localparam int PUC = 50;
   localparam int STC = 20;
   logic clock, nrst, strap, ref_lvl, src_pin, ok, b;
   logic [1:0] cur, nxt;
   logic [7:0] d, rb;
   int err_total = 0, n_tests = 0, n_loads = 0, base;
   wire strap_pin, strap_out, strap_oe_n, pin_h, pin_l, sda_oe_n, sda_out;
   wire diff, mode, load, busy;
   wire [1:0] idx;
   wire [7:0] r0, r13;
   // Strap resistor loses once the device drives
   assign strap_pin = strap_oe_n ? strap : strap_out;

   cfs_top #(.POWERUP_CYCLES(PUC), .SETTLE_CYCLES(STC), .CFG3(16'h8003))
      u_dut (.clock(clock), .nrst(nrst), .strap_select_pin_in(strap_pin),
      .strap_select_pin_out(strap_out), .strap_select_pin_oe_n(strap_oe_n),
      .ref_out_level(ref_lvl), .cfg_sel_high_sda_in(pin_h),
      .cfg_sel_high_sda_out(sda_out), .cfg_sel_high_sda_oe_n(sda_oe_n),
      .cfg_sel_low_scl_in(pin_l), .input_source_pin(src_pin),
      .diff_input_selected(diff), .hw_select_mode(mode),
      .config_index(idx), .config_load(load), .config_busy(busy),
      .stored_defaults_reg(r0), .input_source_polarity_config(r13));
   cfs_host_model u_host (.clock(clock), .dev_sda_oe_n(sda_oe_n),
      .pin_high(pin_h), .pin_low(pin_l));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) if (load === 1'b1) n_loads++;

   function automatic logic [1:0] exp_idx(input logic [1:0] c,
         input logic f);
      // Configuration 3 holds the defaults flag, which locks the pins
      return (c == 2'h3) ? c : c ^ {f, ~f};
   endfunction
   task automatic check(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      if (n == 5000) begin
         err_total++;
         summarize;
      end
   endtask
   task automatic boot(input logic s, input logic [1:0] pins);
      @(posedge clock);
      nrst <= 1'b0;
      strap <= s;
      u_host.set_both(pins);
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      wait_idle;
   endtask
   task automatic src_step(input logic p, input logic pol);
      @(posedge clock);
      ref_lvl <= 1'($urandom);
      src_pin <= p;
      repeat (6) @(negedge clock);
      check("ref_out", {7'h0, ref_lvl}, {7'h0, strap_out});
      check("diff_sel", {7'h0, p ^ pol}, {7'h0, diff});
   endtask

   initial begin
      nrst = 1'b0;
      strap = 1'b0;
      ref_lvl = 1'b0;
      src_pin = 1'b0;
      void'($urandom(74708));
      for (int k = 0; k < 4; k++) begin
         cur = 2'(k);
         base = n_loads;
         boot(1'b1, cur);
         check("mode", 8'h01, {7'h0, mode});
         check("index", {6'h0, cur}, {6'h0, idx});
         check("boot_loads", 8'h01, 8'(n_loads - base));
         check("strap_oe_n", 8'h00, {7'h0, strap_oe_n});
         src_step(1'b0, cur[1]);
         src_step(1'b1, cur[1]);
      end
      // Flag set: pins refused, serial port silent
      check("defaults_reg", 8'h80, r0);
      repeat (PUC) @(posedge clock);
      base = n_loads;
      u_host.flip_one(1'b0);
      repeat (STC + 10) @(negedge clock);
      check("refused_loads", 8'h00, 8'(n_loads - base));
      u_host.flip_one(1'b0);
      u_host.write_reg({`CFS_I2C_ADDR, 1'b0}, 8'h13, 8'h42, ok);
      check("pin_mode_ack", 8'h00, {7'h0, ok});
      check("pin_mode_reg", 8'h03, r13);
      // Random single-pin walk
      cur = 2'h0;
      boot(1'b1, cur);
      repeat (PUC) @(posedge clock);
      for (int s = 0; s < 10; s++) begin
         b = 1'($urandom);
         base = n_loads;
         nxt = exp_idx(cur, b);
         u_host.flip_one(b);
         repeat (8) @(negedge clock);
         wait_idle;
         check("dyn_index", {6'h0, nxt}, {6'h0, idx});
         check("dyn_loads", {7'h0, cur != 2'h3}, 8'(n_loads - base));
         cur = nxt;
      end
      // Serial mode
      base = n_loads;
      boot(1'b0, 2'h3);
      check("mode_serial", 8'h00, {7'h0, mode});
      u_host.write_reg({`CFS_I2C_ADDR ^ 7'h01, 1'b0}, 8'h13, 8'h02, ok);
      check("wrong_addr_ack", 8'h00, {7'h0, ok});
      check("wrong_addr_reg", 8'h00, r13);
      d = (8'($urandom) & 8'h7d) | 8'h02;
      u_host.write_reg({`CFS_I2C_ADDR, 1'b0}, 8'h13, d, ok);
      check("ack", 8'h01, {7'h0, ok});
      check("polarity_reg", d, r13);
      u_host.read_reg({`CFS_I2C_ADDR, 1'b0}, 8'h13, rb, ok);
      check("read_ack", 8'h01, {7'h0, ok});
      check("read_back", d, rb);
      check("sda_out", 8'h00, {7'h0, sda_out});
      check("serial_loads", 8'h01, 8'(n_loads - base));
      src_step(1'b0, 1'b1);
      src_step(1'b1, 1'b1);
      u_host.write_reg({`CFS_I2C_ADDR, 1'b0}, 8'h13, 8'h80, ok);
      repeat (6) @(negedge clock);
      check("frozen_sel", 8'h00, {7'h0, diff});
      summarize;
   end
endmodule // cfs_tb_top

`default_nettype wire
